// ==== core/cmsq_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Pin is asynchronous to aclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module cmsq_pin_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin side
  input  wire logic pin,
  // Filtered outputs
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  logic lvl_nxt, rise_nxt, fall_nxt;

  always_comb begin
    lvl_nxt  = lvl_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    if (s2_r == s3_r) begin
      lvl_nxt  = s3_r;
      rise_nxt = s3_r & ~lvl_r;
      fall_nxt = ~s3_r & lvl_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      s1_r   <= pin;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign level = lvl_r;
  assign rise  = rise_r;
  assign fall  = fall_r;

endmodule : cmsq_pin_sync
`default_nettype wire

// ==== core/cmsq_pkg.sv ====
// Purpose: Constants and types shared by the counter mode sequencer.
// Assumes: One counter, down counting, register bus is AXI4-Lite with 32-bit data.
// Notes:   Functional notes follow.
//
// Functional notes
// [R01] Mode comes from gate field plus three bits.
// [R02] Host never programs reserved mode combinations.
// [R03] Repetition bit 0 disarms at end, 1 repeats.
// [R04] Only active-going source and gate edges count.
// [R05] Terminal count state always counts next edge.
// [R06] Mode A: armed counts, reload, disarm.
// [R07] Mode B: count only while gate active.
// [R08] Modes C, F: gate edges ignored while disarmed.
// [R09] Mode C: start after gate edge, disarm.
// [R10] Host restarts mode C: arm, then gate.
// [R11] Mode C: gate ignored after triggering edge.
// [R12] Mode D: repeat forever, reload from load.
// [R13] Mode E: like D, gated by level.
// [R14] Mode F: gate starts, stop, stay armed.
// [R15] Mode G: two terminal counts, then disarm.
// [R16] Mode G: hold first, load second reload.
// [R17] Host preloads mode G before arming.
// [R18] Mode G: count sets delay, hold sets width.
// [R19] Arm, disarm and load commands per counter.
// [R20] Terminal count pulse and toggled output.
package cmsq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_LOAD   = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int GC_HI        = 15;
  localparam int GC_LO        = 13;
  localparam int SPECIAL_BIT  = 7;
  localparam int RELOAD_BIT   = 6;
  localparam int REPEAT_BIT   = 5;
  localparam int CMD_ARM_BIT  = 0;
  localparam int CMD_DIS_BIT  = 1;
  localparam int CMD_LOAD_BIT = 2;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [2:0]  GC_NONE    = 3'h0;
  localparam logic [1:0]  GC_LEVEL   = 2'h2;
  localparam logic [1:0]  GC_EDGE    = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    MD_NONE = 8'h01, MD_A = 8'h02, MD_B = 8'h04, MD_C = 8'h08,
    MD_D    = 8'h10, MD_E = 8'h20, MD_F = 8'h40, MD_G = 8'h80
  } cmsq_mode_e;

  typedef enum logic [2:0] {
    ST_DIS  = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN  = 3'h4
  } cmsq_state_e;

endpackage : cmsq_pkg

// ==== core/cmsq_top.sv ====
// Purpose: One counter with modes A to G, register access over AXI4-Lite.
// Assumes: Gate and source are asynchronous pins; source counts on rising edges.
// Notes:   Unsupported mode codes leave the counter idle and flag it in status.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cmsq_top #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Counter pins
  input  wire logic        gate_pin,
  input  wire logic        source_pin,
  output logic             tc_out,
  output logic             tc_toggle_out,
  output logic             armed_out
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic cmsq_pkg::cmsq_mode_e decode_mode(input logic [15:0] m);
    logic [2:0] gc;
    logic [2:0] bits;
    gc   = m[cmsq_pkg::GC_HI:cmsq_pkg::GC_LO];
    bits = {m[cmsq_pkg::SPECIAL_BIT], m[cmsq_pkg::RELOAD_BIT], m[cmsq_pkg::REPEAT_BIT]};
    decode_mode = cmsq_pkg::MD_NONE;
    unique case (bits)
      3'h0: begin
        if (gc == cmsq_pkg::GC_NONE) decode_mode = cmsq_pkg::MD_A;
        else if (gc[2:1] == cmsq_pkg::GC_LEVEL) decode_mode = cmsq_pkg::MD_B;
        else if (gc[2:1] == cmsq_pkg::GC_EDGE) decode_mode = cmsq_pkg::MD_C;
      end
      3'h1: begin
        if (gc == cmsq_pkg::GC_NONE) decode_mode = cmsq_pkg::MD_D;
        else if (gc[2:1] == cmsq_pkg::GC_LEVEL) decode_mode = cmsq_pkg::MD_E;
        else if (gc[2:1] == cmsq_pkg::GC_EDGE) decode_mode = cmsq_pkg::MD_F;
      end
      3'h2: begin
        if (gc == cmsq_pkg::GC_NONE) decode_mode = cmsq_pkg::MD_G;
      end
      default: decode_mode = cmsq_pkg::MD_NONE;
    endcase
  endfunction : decode_mode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]           mode_r, mode_nxt;
  logic [CW-1:0]         load_r, load_nxt, hold_r, hold_nxt, cnt_r, cnt_nxt;
  cmsq_pkg::cmsq_state_e st_r, st_nxt;
  logic                  phase_r, phase_nxt, tc_r, tc_nxt, tog_r, tog_nxt;
  logic                  pend_r, pend_nxt, tcp_r, tcp_nxt;
  logic [7:0]            awaddr_r, awaddr_nxt;
  logic                  awhave_r, awhave_nxt, whave_r, whave_nxt;
  logic [31:0]           wdata_r, wdata_nxt;
  logic [3:0]            wstrb_r, wstrb_nxt;
  logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]            bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]           rdata_r, rdata_nxt;

  logic gate_lvl, gate_rise, gate_fall, src_rise;
  cmsq_pkg::cmsq_mode_e mode;
  logic gate_act, gate_edge, is_level, is_edge, qual;
  logic wr_fire, cmd_arm, cmd_dis, cmd_ld, cmd_any;

  cmsq_pin_sync u_gate_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (gate_pin),
    .level   (gate_lvl),
    .rise    (gate_rise),
    .fall    (gate_fall)
  );

  cmsq_pin_sync u_src_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (source_pin),
    .level   (),
    .rise    (src_rise),
    .fall    ()
  );

  // Low bit of the gate field selects active-low gating.
  assign mode      = decode_mode(mode_r);                                   // [R01]
  assign gate_act  = mode_r[cmsq_pkg::GC_LO] ? ~gate_lvl : gate_lvl;
  assign gate_edge = mode_r[cmsq_pkg::GC_LO] ? gate_fall : gate_rise;       // [R04]
  assign is_level  = (mode == cmsq_pkg::MD_B) || (mode == cmsq_pkg::MD_E);
  assign is_edge   = (mode == cmsq_pkg::MD_C) || (mode == cmsq_pkg::MD_F);
  assign qual      = src_rise && (!is_level || gate_act);                   // [R07] [R13]

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !awhave_r;
  assign s_axi_wready  = !whave_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_fire = awhave_r && whave_r && !bvalid_r;
  assign cmd_any = wr_fire && (awaddr_r == cmsq_pkg::OFS_CMD) && wstrb_r[0];
  assign cmd_arm = cmd_any && wdata_r[cmsq_pkg::CMD_ARM_BIT];               // [R19]
  assign cmd_dis = cmd_any && wdata_r[cmsq_pkg::CMD_DIS_BIT];
  assign cmd_ld  = cmd_any && wdata_r[cmsq_pkg::CMD_LOAD_BIT];

  always_comb begin
    awaddr_nxt = awaddr_r;
    awhave_nxt = awhave_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    whave_nxt  = whave_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    mode_nxt   = mode_r;
    load_nxt   = load_r;
    hold_nxt   = hold_r;
    if (s_axi_awvalid && !awhave_r) begin
      awaddr_nxt = s_axi_awaddr;
      awhave_nxt = 1'b1;
    end
    if (s_axi_wvalid && !whave_r) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      whave_nxt = 1'b1;
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (wr_fire) begin
      awhave_nxt = 1'b0;
      whave_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = cmsq_pkg::RESP_OKAY;
      for (int b = 0; b < 2; b++) begin
        if (wstrb_r[b]) begin
          unique case (awaddr_r)
            cmsq_pkg::OFS_MODE: mode_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
            cmsq_pkg::OFS_LOAD: load_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
            cmsq_pkg::OFS_HOLD: hold_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (awaddr_r != cmsq_pkg::OFS_MODE && awaddr_r != cmsq_pkg::OFS_LOAD &&
          awaddr_r != cmsq_pkg::OFS_HOLD && awaddr_r != cmsq_pkg::OFS_CMD)
        bresp_nxt = cmsq_pkg::RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = cmsq_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case (s_axi_araddr)
        cmsq_pkg::OFS_MODE:   rdata_nxt[15:0]   = mode_r;
        cmsq_pkg::OFS_LOAD:   rdata_nxt[CW-1:0] = load_r;
        cmsq_pkg::OFS_HOLD:   rdata_nxt[CW-1:0] = hold_r;
        cmsq_pkg::OFS_CMD:    rdata_nxt         = 32'h0000_0000;
        cmsq_pkg::OFS_STATUS: rdata_nxt[6:0]    = {pend_r, mode == cmsq_pkg::MD_NONE, phase_r,
                                                   tog_r, tc_r, st_r == cmsq_pkg::ST_WAIT,
                                                   st_r != cmsq_pkg::ST_DIS};
        cmsq_pkg::OFS_COUNT:  rdata_nxt[CW-1:0] = cnt_r;
        default:              rresp_nxt         = cmsq_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Count sequencer
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt   = cnt_r;
    st_nxt    = st_r;
    phase_nxt = phase_r;
    tc_nxt    = tc_r;
    tog_nxt   = tog_r;
    pend_nxt  = pend_r;
    tcp_nxt   = 1'b0;
    if (tc_r && src_rise) begin
      // Leaving terminal count happens regardless of gate or arm state.
      tc_nxt   = 1'b0;                                                      // [R05]
      pend_nxt = 1'b0;
      cnt_nxt  = (mode == cmsq_pkg::MD_G && !phase_r) ? hold_r : load_r;    // [R16] [R18]
      unique case (mode)
        cmsq_pkg::MD_A, cmsq_pkg::MD_B, cmsq_pkg::MD_C: st_nxt = cmsq_pkg::ST_DIS; // [R03] [R06] [R07] [R09]
        cmsq_pkg::MD_F: if (st_r != cmsq_pkg::ST_DIS) st_nxt = cmsq_pkg::ST_WAIT;   // [R14]
        cmsq_pkg::MD_G: begin
          phase_nxt = !phase_r;                                             // [R15]
          if (phase_r) st_nxt = cmsq_pkg::ST_DIS;
        end
        default: ;                                                          // [R12] [R13]
      endcase
      if (pend_r) begin
        st_nxt    = cmsq_pkg::ST_DIS;
        phase_nxt = 1'b0;
      end
    end else if (!tc_r && st_r == cmsq_pkg::ST_RUN && qual && mode != cmsq_pkg::MD_NONE) begin
      // Gate level is not looked at here in modes C and F.
      if (cnt_r == CW'(1)) begin                                            // [R11]
        cnt_nxt = '0;
        tc_nxt  = 1'b1;
        tcp_nxt = 1'b1;                                                     // [R20]
        tog_nxt = !tog_r;
      end else begin
        cnt_nxt = cnt_r - CW'(1);
      end
    end else if (st_r == cmsq_pkg::ST_WAIT && gate_edge) begin
      st_nxt = cmsq_pkg::ST_RUN;                                            // [R08] [R09] [R14]
    end
    if (cmd_dis) begin
      // A disarm during terminal count waits for the edge that ends it.
      if (tc_r && !src_rise) pend_nxt = 1'b1;                               // [R05]
      else begin
        st_nxt    = cmsq_pkg::ST_DIS;
        phase_nxt = 1'b0;
      end
    end else if (cmd_arm && st_r == cmsq_pkg::ST_DIS && mode != cmsq_pkg::MD_NONE) begin
      st_nxt    = is_edge ? cmsq_pkg::ST_WAIT : cmsq_pkg::ST_RUN;           // [R19]
      phase_nxt = 1'b0;
    end
    if (cmd_ld) cnt_nxt = load_r;                                           // [R17]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= 8'h00;
      awhave_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      whave_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= cmsq_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= cmsq_pkg::RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      mode_r   <= cmsq_pkg::MODE_RESET;
      load_r   <= '0;
      hold_r   <= '0;
      cnt_r    <= '0;
      st_r     <= cmsq_pkg::ST_DIS;
      phase_r  <= 1'b0;
      tc_r     <= 1'b0;
      tog_r    <= 1'b0;
      pend_r   <= 1'b0;
      tcp_r    <= 1'b0;
    end else begin
      awaddr_r <= awaddr_nxt;
      awhave_r <= awhave_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      whave_r  <= whave_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      mode_r   <= mode_nxt;
      load_r   <= load_nxt;
      hold_r   <= hold_nxt;
      cnt_r    <= cnt_nxt;
      st_r     <= st_nxt;
      phase_r  <= phase_nxt;
      tc_r     <= tc_nxt;
      tog_r    <= tog_nxt;
      pend_r   <= pend_nxt;
      tcp_r    <= tcp_nxt;
    end
  end

  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign tc_out        = tcp_r;
  assign tc_toggle_out = tog_r;
  assign armed_out     = (st_r != cmsq_pkg::ST_DIS);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic tc_exit;
  assign tc_exit = tc_r && src_rise;

  a_tc_toggle_pair: assert property (tc_out |-> tc_r && (tc_toggle_out != $past(tc_toggle_out))) // [R20]
    else $error("toggle did not flip with terminal count");
  a_tc_one_pulse: assert property (tc_out |=> !tc_out)                                    // [R20]
    else $error("terminal count pulse longer than one cycle");
  a_tc_holds_zero: assert property (tc_r && !src_rise && !cmd_ld |=> tc_r && cnt_r == '0) // [R05]
    else $error("terminal count left without a source edge");
  a_once_disarm: assert property (tc_exit && (mode == cmsq_pkg::MD_A || mode == cmsq_pkg::MD_C)
                                  |=> st_r == cmsq_pkg::ST_DIS && (cnt_r == $past(load_r) || $past(cmd_ld))) // [R06]
    else $error("strobe mode did not reload and disarm");
  a_rate_repeat: assert property (tc_exit && mode == cmsq_pkg::MD_D && st_r == cmsq_pkg::ST_RUN
                                  && !pend_r && !cmd_dis |=> st_r == cmsq_pkg::ST_RUN) // [R12]
    else $error("rate generator stopped at terminal count");
  a_oneshot_wait: assert property (tc_exit && mode == cmsq_pkg::MD_F && st_r != cmsq_pkg::ST_DIS
                                   && !pend_r && !cmd_dis |=> st_r == cmsq_pkg::ST_WAIT) // [R14]
    else $error("one-shot did not return to waiting for gate");
  a_g_hold_first: assert property (tc_exit && mode == cmsq_pkg::MD_G && !phase_r && !cmd_ld && !pend_r
                                   && !cmd_dis |=> cnt_r == $past(hold_r) && phase_r)       // [R16]
    else $error("first terminal count did not reload from hold");
  a_g_second_dis: assert property (tc_exit && mode == cmsq_pkg::MD_G && phase_r
                                   |=> st_r == cmsq_pkg::ST_DIS && !phase_r)    // [R15]
    else $error("delayed pulse did not disarm at second terminal count");
  a_level_blocks: assert property (st_r == cmsq_pkg::ST_RUN && is_level && !gate_act && !tc_r
                                   && !cmd_any |=> $stable(cnt_r))                // [R07]
    else $error("counted while gate inactive");
  a_disarmed_gate: assert property (st_r == cmsq_pkg::ST_DIS && gate_edge && !cmd_any
                                    |=> st_r == cmsq_pkg::ST_DIS)                // [R08]
    else $error("gate edge acted on disarmed counter");
  a_wait_no_count: assert property (st_r == cmsq_pkg::ST_WAIT && !tc_r && !cmd_any
                                    |=> $stable(cnt_r))                          // [R09]
    else $error("counted before triggering gate edge");
  a_src_only: assert property (!src_rise && !cmd_ld |=> $stable(cnt_r))           // [R04]
    else $error("count moved without a source edge");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");

  c_g_two_tc:   cover property (tc_exit && mode == cmsq_pkg::MD_G && phase_r);
  c_f_rewait:   cover property (tc_exit && mode == cmsq_pkg::MD_F ##1 st_r == cmsq_pkg::ST_WAIT);
  c_pend_dis:   cover property (pend_r ##[1:50] tc_exit);
  c_level_hold: cover property (st_r == cmsq_pkg::ST_RUN && is_level && src_rise && !gate_act);

endmodule : cmsq_top
`default_nettype wire

// ==== test/cmsq_pins_model.sv ====
// Purpose: Drives the gate and source pins as outside logic would.
// Assumes: Gate is active high; source counts on rising edges.
// Notes:   Pulses last five clocks so the pin filter keeps them.
`timescale 1ns/1ps
`default_nettype none
module cmsq_pins_model (
  // Clock
  input  wire logic aclk,
  // Pins
  output logic      gate_pin,
  output logic      source_pin
);
  initial begin
    gate_pin   = 1'b0;
    source_pin = 1'b0;
  end

  // Only the rising half of each pulse should advance the counter.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk) source_pin <= 1'b1;
      repeat (5) @(posedge aclk);
      source_pin <= 1'b0;
      repeat (5) @(posedge aclk);
    end
  endtask : pulses

  task automatic set_gate(input logic g);
    @(posedge aclk) gate_pin <= g;
    repeat (8) @(posedge aclk);
  endtask : set_gate

  // A rising gate edge; the level falls again so a level-sensitive fault shows.
  task automatic gate_edge();
    set_gate(1'b1);
    set_gate(1'b0);
  endtask : gate_edge
endmodule : cmsq_pins_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the counter mode sequencer.
// Assumes: LOAD is 2 and HOLD is 1 in every mode run.
// Notes:   Terminal counts are tallied from tc_out by a monitor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdv;
  logic [1:0]  rsp;
  wire logic   awr, wrdy, bv, arr, rv, tc, tgl, armed, gate, src;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat;
  int n_mismatch = 0, n_tests = 0, n_tc = 0, cyc = 0;

  cmsq_top cmsq_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .gate_pin(gate), .source_pin(src), .tc_out(tc), .tc_toggle_out(tgl), .armed_out(armed));
  cmsq_pins_model cmsq_pins_model_inst (.aclk(aclk), .gate_pin(gate), .source_pin(src));

  initial begin
    forever #25 aclk = ~aclk;
  end

  // The ceiling is far above the longest run of mode scenarios.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tc === 1'b1) n_tc <= n_tc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        r = br;
        break;
      end
    end
    bry <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d = rdat;
        r = rr;
        break;
      end
    end
    rry <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_and_map();
    rd(cmsq_pkg::OFS_MODE, rdv, rsp);
    check("mode reset", rdv, 32'h0000_0000);
    check("armed reset", {31'h0, armed}, 32'h0);
    rd(8'h18, rdv, rsp);
    check("unmapped rresp", {30'h0, rsp}, {30'h0, cmsq_pkg::RESP_SLVERR});
    wr(8'h18, 32'h0000_00FF, rsp);
    check("unmapped bresp", {30'h0, rsp}, {30'h0, cmsq_pkg::RESP_SLVERR});
    wr(cmsq_pkg::OFS_LOAD, 32'h0000_0002, rsp);
    wr(cmsq_pkg::OFS_HOLD, 32'h0000_0001, rsp);
    rd(cmsq_pkg::OFS_LOAD, rdv, rsp);
    check("load readback", rdv, 32'h0000_0002);
    rd(cmsq_pkg::OFS_CMD, rdv, rsp);
    check("cmd reads zero", rdv, 32'h0000_0000);
  endtask : reset_and_map

  // A mode outside A to G is stored but never lets the counter arm.
  task automatic none_mode();
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0002, rsp);
    wr(cmsq_pkg::OFS_MODE, 32'h0000_0060, rsp);
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0001, rsp);
    rd(cmsq_pkg::OFS_STATUS, rdv, rsp);
    check("none unsupported", {31'h0, rdv[5]}, 32'h1);
    check("none armed", {31'h0, armed}, 32'h0);
  endtask : none_mode

  // A disarm in terminal count waits for the source edge that ends it.
  task automatic dis_in_tc();
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0002, rsp);
    wr(cmsq_pkg::OFS_MODE, 32'h0000_0020, rsp);
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0004, rsp);
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0001, rsp);
    cmsq_pins_model_inst.pulses(2);
    repeat (8) @(posedge aclk);
    rd(cmsq_pkg::OFS_STATUS, rdv, rsp);
    check("pend in tc", {31'h0, rdv[2]}, 32'h1);
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0002, rsp);
    rd(cmsq_pkg::OFS_STATUS, rdv, rsp);
    check("pend flag", {31'h0, rdv[6]}, 32'h1);
    check("pend armed", {31'h0, armed}, 32'h1);
    cmsq_pins_model_inst.pulses(1);
    repeat (8) @(posedge aclk);
    check("pend disarmed", {31'h0, armed}, 32'h0);
    rd(cmsq_pkg::OFS_COUNT, rdv, rsp);
    check("pend reload", rdv, 32'h0000_0002);
  endtask : dis_in_tc

  // e[0] gives a gate edge before arming, e[1] one after arming.
  task automatic run(input string nm, input logic [15:0] md, input logic g, input logic [1:0] e,
                     input int np, input int ntc, input logic arm_end);
    int   t0;
    logic tg0;
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0002, rsp);
    wr(cmsq_pkg::OFS_MODE, {16'h0, md}, rsp);
    cmsq_pins_model_inst.set_gate(g);
    if (e[0]) cmsq_pins_model_inst.gate_edge();
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0004, rsp);
    wr(cmsq_pkg::OFS_CMD, 32'h0000_0001, rsp);
    repeat (2) @(posedge aclk);
    check({nm, " armed"}, {31'h0, armed}, 32'h1);
    if (e[1]) cmsq_pins_model_inst.gate_edge();
    t0  = n_tc;
    tg0 = tgl;
    cmsq_pins_model_inst.pulses(np);
    repeat (8) @(posedge aclk);
    check({nm, " tc count"}, n_tc - t0, ntc);
    check({nm, " toggle"}, {31'h0, tgl}, {31'h0, tg0 ^ ntc[0]});
    check({nm, " armed end"}, {31'h0, armed}, {31'h0, arm_end});
    rd(cmsq_pkg::OFS_COUNT, rdv, rsp);
    check({nm, " count"}, rdv, 32'h0000_0002);
  endtask : run

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    reset_and_map();
    run("A", 16'h0000, 1'b0, 2'b00, 3, 1, 1'b0);
    run("B low", 16'h8000, 1'b0, 2'b00, 2, 0, 1'b1);
    run("B high", 16'h8000, 1'b1, 2'b00, 3, 1, 1'b0);
    run("B inv", 16'hA000, 1'b0, 2'b00, 3, 1, 1'b0);
    run("C idle", 16'hC000, 1'b0, 2'b01, 3, 0, 1'b1);
    run("C trig", 16'hC000, 1'b0, 2'b10, 3, 1, 1'b0);
    run("D", 16'h0020, 1'b0, 2'b00, 6, 2, 1'b1);
    run("E low", 16'h8020, 1'b0, 2'b00, 3, 0, 1'b1);
    run("E high", 16'h8020, 1'b1, 2'b00, 6, 2, 1'b1);
    run("F", 16'hC020, 1'b0, 2'b10, 6, 1, 1'b1);
    run("G", 16'h0040, 1'b0, 2'b00, 7, 2, 1'b0);
    none_mode();
    dis_in_tc();
    test_done();
  end
endmodule : testbench
`default_nettype wire
